// ===== verilog/lsi_top.sv
// link status indicator: panel LEDs, level bar, summary lamp, switching output, APB registers
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "lsi_cfg.svh"

module lsi_top #(
    parameter int unsigned FLASH_HALF_CYC = `LSI_FLASH_HALF_NS / `LSI_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_b_i,
    // apb slave
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [`LSI_ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]            pwdata_i,
    input  wire logic [3:0]             pstrb_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    // link states from the device
    input  wire logic                   optical_link_up_i,
    input  wire logic                   optical_activity_i,
    input  wire logic                   cable_link_up_i,
    input  wire logic                   cable_activity_i,
    input  wire logic                   remote_cable_missing_i,
    input  wire logic                   remote_bar_empty_i,
    input  wire logic [3:0]             rx_level_i,
    // warnings from the device
    input  wire logic [7:0]             temp_excess_degc_i,
    input  wire logic                   laser_prefailure_warning_i,
    input  wire logic                   link_loss_counter_trigger_i,
    // indicators and outputs
    output logic      [1:0]             optical_link_led_o,
    output logic      [1:0]             link_error_led_o,
    output logic      [1:0]             cable_link_led_o,
    output logic      [1:0]             connector_link_activity_led_o,
    output logic      [`LSI_SEG_COUNT-1:0] level_bar_o,
    output logic      [1:0]             temperature_warning_led_o,
    output logic                        status_lamp_o,
    output logic                        switching_output_one_o,
    output logic                        tx_active_o
);

    if (FLASH_HALF_CYC < 2) begin : g_chk
        $error("FLASH_HALF_CYC must be at least 2");
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] lsi_clamp(input logic [3:0] lvl);
        lsi_clamp = (lvl > `LSI_LEVEL_MAX) ? `LSI_LEVEL_MAX : lvl;
    endfunction

    // segment 0 is the lowest red one, 7 the highest green one
    function automatic logic [`LSI_SEG_COUNT-1:0] lsi_bar(input logic [3:0] lvl);
        lsi_bar = '0;
        for (int i = 0; i < `LSI_SEG_COUNT; i++) begin
            lsi_bar[i] = (4'(i) < lvl);
        end
    endfunction

    function automatic lsi_pkg::lsi_color_t lsi_link_color(input logic up, input logic act);
        if (!up) begin
            lsi_link_color = lsi_pkg::LSI_OFF;
        end else if (act) begin
            lsi_link_color = lsi_pkg::LSI_ORANGE;
        end else begin
            lsi_link_color = lsi_pkg::LSI_GREEN;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    logic [31:0]          ctrl_ff;
    logic [31:0]          prdata_ff;
    logic                 pready_ff;
    logic                 pslverr_ff;
    logic [31:0]          status_word;
    logic                 apb_setup;
    logic                 apb_access;
    logic                 hit_ctrl;
    logic                 hit_stat;
    lsi_pkg::lsi_mode_t   mode;
    logic                 tx_enable;

    assign apb_setup  = psel_i && !penable_i;
    assign apb_access = psel_i && penable_i && pready_ff;
    assign hit_ctrl   = (paddr_i == `LSI_ADDR_CTRL);
    assign hit_stat   = (paddr_i == `LSI_ADDR_STAT);
    // an undefined mode code is served as manual, the cautious choice
    assign mode       = (ctrl_ff[`LSI_CTRL_MODE_MSB:`LSI_CTRL_MODE_LSB] == 2'h3) ?
                        lsi_pkg::LSI_MANUAL_MODE :
                        lsi_pkg::lsi_mode_t'(ctrl_ff[`LSI_CTRL_MODE_MSB:`LSI_CTRL_MODE_LSB]);
    assign tx_enable  = ctrl_ff[`LSI_CTRL_TXEN_BIT];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_ff <= `LSI_CTRL_RESET;
        end else if (apb_access && pwrite_i && hit_ctrl) begin
            for (int b = 0; b < 4; b++) begin
                if (pstrb_i[b]) begin
                    ctrl_ff[b*8 +: 8] <= pwdata_i[b*8 +: 8];
                end
            end
            ctrl_ff[31:`LSI_CTRL_MODE_MSB+1] <= '0;
        end
    end

    // zero wait states; read data and error are prepared in the setup cycle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= 1'b1;
            if (apb_setup) begin
                pslverr_ff <= !(hit_ctrl || (hit_stat && !pwrite_i));
                if (pwrite_i) begin
                    prdata_ff <= 32'h00000000;
                end else if (hit_ctrl) begin
                    prdata_ff <= ctrl_ff;
                end else if (hit_stat) begin
                    prdata_ff <= status_word;
                end else begin
                    prdata_ff <= 32'h00000000;
                end
            end
        end
    end

    assign prdata_o  = prdata_ff;
    assign pready_o  = pready_ff;
    assign pslverr_o = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////////
    logic [3:0] level;
    logic       has_green;
    logic       only_red;
    logic       minimal_margin;
    logic       optical_present;
    logic       temp_warn;
    logic       temp_err;
    logic       any_warning;

    assign level           = lsi_clamp(rx_level_i);
    assign has_green       = (level > `LSI_ORANGE_TOP);
    assign only_red        = (level <= `LSI_RED_TOP);
    assign minimal_margin  = !has_green && !only_red;
    assign optical_present = optical_link_up_i && !only_red;
    assign temp_warn       = (temp_excess_degc_i != 8'h00) &&
                             (temp_excess_degc_i <= `LSI_TEMP_WARN_DEGC);
    assign temp_err        = (temp_excess_degc_i > `LSI_TEMP_WARN_DEGC);
    assign any_warning     = !has_green || temp_warn || temp_err ||
                             laser_prefailure_warning_i ||
                             link_loss_counter_trigger_i;

    // flash divider: one-cycle tick every half period
    logic [31:0] flash_cnt_ff;
    logic        flash_tick;
    logic        flash_phase_ff;

    assign flash_tick = (flash_cnt_ff == FLASH_HALF_CYC - 1);

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_cnt_ff <= 32'h00000000;
        end else if (flash_tick) begin
            flash_cnt_ff <= 32'h00000000;
        end else begin
            flash_cnt_ff <= flash_cnt_ff + 32'h00000001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flash_phase_ff <= 1'b0;
        end else if (flash_tick) begin
            flash_phase_ff <= !flash_phase_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    lsi_pkg::lsi_color_t nxt_optical_led;
    lsi_pkg::lsi_color_t nxt_error_led;
    lsi_pkg::lsi_color_t nxt_cable_led;
    lsi_pkg::lsi_color_t nxt_temp_led;
    logic                nxt_lamp;
    logic                nxt_switch;
    logic                nxt_tx;
    logic                lamp_off;

    assign nxt_optical_led = lsi_link_color(optical_present, optical_activity_i);
    assign nxt_cable_led   = lsi_link_color(cable_link_up_i, cable_activity_i);
    assign nxt_switch      = minimal_margin || only_red;
    assign lamp_off        = only_red || !cable_link_up_i || !tx_enable;

    always_comb begin
        // own faults outrank the opposite device's report
        if (!cable_link_up_i || !has_green && only_red || level <= `LSI_RED_TOP) begin
            nxt_error_led = lsi_pkg::LSI_RED;
        end else if (remote_cable_missing_i || remote_bar_empty_i) begin
            nxt_error_led = lsi_pkg::LSI_ORANGE;
        end else begin
            nxt_error_led = lsi_pkg::LSI_OFF;
        end
    end

    always_comb begin
        nxt_tx = tx_enable && optical_link_up_i && !only_red;
        if (minimal_margin && mode != lsi_pkg::LSI_AUTOMATIC_MODE) begin
            nxt_tx = 1'b0;
        end
    end

    always_comb begin
        if (lamp_off) begin
            nxt_lamp = 1'b0;
        end else if (any_warning) begin
            nxt_lamp = flash_phase_ff;
        end else begin
            nxt_lamp = 1'b1;
        end
    end

    always_comb begin
        if (temp_err) begin
            nxt_temp_led = lsi_pkg::LSI_RED;
        end else if (temp_warn) begin
            nxt_temp_led = lsi_pkg::LSI_ORANGE;
        end else begin
            nxt_temp_led = lsi_pkg::LSI_OFF;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            optical_link_led_o            <= lsi_pkg::LSI_OFF;
            link_error_led_o              <= lsi_pkg::LSI_OFF;
            cable_link_led_o              <= lsi_pkg::LSI_OFF;
            connector_link_activity_led_o <= lsi_pkg::LSI_OFF;
            temperature_warning_led_o     <= lsi_pkg::LSI_OFF;
        end else begin
            optical_link_led_o            <= nxt_optical_led;
            link_error_led_o              <= nxt_error_led;
            cable_link_led_o              <= nxt_cable_led;
            connector_link_activity_led_o <= nxt_cable_led;
            temperature_warning_led_o     <= nxt_temp_led;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            level_bar_o <= '0;
        end else begin
            level_bar_o <= lsi_bar(level);
        end
    end

    // transmission is held off during reset until the link state is known
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            status_lamp_o          <= 1'b0;
            switching_output_one_o <= 1'b0;
            tx_active_o            <= 1'b0;
        end else begin
            status_lamp_o          <= nxt_lamp;
            switching_output_one_o <= nxt_switch;
            tx_active_o            <= nxt_tx;
        end
    end

    always_comb begin
        status_word = 32'h00000000;
        status_word[`LSI_STAT_BAR_LSB +: `LSI_SEG_COUNT] = level_bar_o;
        status_word[`LSI_STAT_OLK_LSB +: 2]  = optical_link_led_o;
        status_word[`LSI_STAT_ERR_LSB +: 2]  = link_error_led_o;
        status_word[`LSI_STAT_CBL_LSB +: 2]  = cable_link_led_o;
        status_word[`LSI_STAT_LAMP_BIT]      = status_lamp_o;
        status_word[`LSI_STAT_SW1_BIT]       = switching_output_one_o;
        status_word[`LSI_STAT_TX_BIT]        = tx_active_o;
        status_word[`LSI_STAT_TMP_LSB +: 2]  = temperature_warning_led_o;
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i || !pready_ff); // outputs keep reset values one edge past release

    AST_OPTICAL_GREEN: assert property (
        optical_link_up_i && !optical_activity_i && level > `LSI_RED_TOP
        |=> optical_link_led_o == lsi_pkg::LSI_GREEN)
        else $error("optical LED not green on idle link");

    AST_OPTICAL_ORANGE: assert property (
        optical_link_up_i && optical_activity_i && level > `LSI_RED_TOP
        |=> optical_link_led_o == lsi_pkg::LSI_ORANGE)
        else $error("optical LED not orange with traffic");

    AST_ERROR_ORANGE: assert property (
        cable_link_up_i && level > `LSI_RED_TOP &&
        (remote_cable_missing_i || remote_bar_empty_i)
        |=> link_error_led_o == lsi_pkg::LSI_ORANGE)
        else $error("error LED not orange on remote fault");

    AST_ERROR_RED: assert property (
        (!cable_link_up_i || level <= `LSI_RED_TOP) |=> link_error_led_o == lsi_pkg::LSI_RED)
        else $error("error LED not red on own fault");

    AST_ERROR_OFF: assert property (
        cable_link_up_i && level > `LSI_RED_TOP &&
        !remote_cable_missing_i && !remote_bar_empty_i
        |=> link_error_led_o == lsi_pkg::LSI_OFF)
        else $error("error LED lit without fault");

    AST_CABLE_LED: assert property (
        !cable_link_up_i |=> cable_link_led_o == lsi_pkg::LSI_OFF)
        else $error("cable LED lit without wired link");

    AST_CABLE_IDLE_ACT: assert property (
        cable_link_up_i |=> cable_link_led_o ==
        ($past(cable_activity_i) ? lsi_pkg::LSI_ORANGE : lsi_pkg::LSI_GREEN))
        else $error("cable LED colour wrong for activity");

    AST_CONNECTOR_MIRROR: assert property (
        connector_link_activity_led_o == cable_link_led_o)
        else $error("connector LED differs from cable LED");

    AST_BAR_FILL: assert property (
        ##1 $countones(level_bar_o) == 32'($past(level)) &&
        (level_bar_o & (level_bar_o + 8'h01)) == 8'h00)
        else $error("level bar not filled from the red end");

    AST_MARGIN_SWITCH: assert property (
        !has_green |=> switching_output_one_o ##1 1'b1)
        else $error("switching output not raised on low margin");

    AST_GREEN_NO_SWITCH: assert property (
        has_green |=> !switching_output_one_o)
        else $error("switching output raised with green margin");

    AST_MANUAL_STOP: assert property (
        minimal_margin && mode != lsi_pkg::LSI_AUTOMATIC_MODE |=> !tx_active_o)
        else $error("transmission not stopped in manual or adjust mode");

    AST_AUTO_RUN: assert property (
        minimal_margin && mode == lsi_pkg::LSI_AUTOMATIC_MODE &&
        tx_enable && optical_link_up_i |=> tx_active_o)
        else $error("transmission stopped in automatic mode");

    AST_RED_STOP: assert property (
        only_red |=> !tx_active_o && optical_link_led_o == lsi_pkg::LSI_OFF)
        else $error("transfer not stopped with only red segments");

    AST_LAMP_OFF: assert property (
        lamp_off |=> !status_lamp_o [*2] or !lamp_off)
        else $error("summary lamp lit while it must be off");

    AST_LAMP_STEADY: assert property (
        !lamp_off && !any_warning |=> status_lamp_o)
        else $error("summary lamp not steady green");

    AST_LAMP_FLASH: assert property (
        !lamp_off && any_warning && !flash_tick && $stable(any_warning)
        ##1 !lamp_off && any_warning |=> $stable(status_lamp_o))
        else $error("warning flash changed off a divider tick");

    AST_TEMP: assert property (
        temp_excess_degc_i > `LSI_TEMP_WARN_DEGC
        |=> temperature_warning_led_o == lsi_pkg::LSI_RED && $past(any_warning))
        else $error("temperature error not shown");

    COV_MIN_MARGIN_AUTO: cover property (
        minimal_margin && mode == lsi_pkg::LSI_AUTOMATIC_MODE ##1 tx_active_o);
    COV_LINK_LOST: cover property (has_green ##1 only_red ##1 switching_output_one_o);
    COV_LAMP_FLASH: cover property (!lamp_off && any_warning && flash_tick);
    COV_APB_WRITE: cover property (apb_access && pwrite_i && hit_ctrl);

endmodule // lsi_top

// ===== verilog/lsi_cfg.svh
// offsets, field positions, reset values and timing in ns of the link status indicator
`ifndef LSI_CFG_SVH
`define LSI_CFG_SVH
`define LSI_ADDR_W          12
`define LSI_ADDR_CTRL       12'h000
`define LSI_ADDR_STAT       12'h004
`define LSI_CTRL_TXEN_BIT   0
`define LSI_CTRL_MODE_LSB   1
`define LSI_CTRL_MODE_MSB   2
`define LSI_CTRL_RESET      32'h00000001
`define LSI_SEG_COUNT       8
`define LSI_LEVEL_MAX       4'h8
`define LSI_RED_TOP         4'h2
`define LSI_ORANGE_TOP      4'h4
`define LSI_TEMP_WARN_DEGC  8'h05
`define LSI_CLK_PERIOD_NS   50
`define LSI_FLASH_HALF_NS   500000000
`define LSI_STAT_BAR_LSB    0
`define LSI_STAT_OLK_LSB    8
`define LSI_STAT_ERR_LSB    10
`define LSI_STAT_CBL_LSB    12
`define LSI_STAT_LAMP_BIT   14
`define LSI_STAT_SW1_BIT    15
`define LSI_STAT_TX_BIT     16
`define LSI_STAT_TMP_LSB    17
`endif

// ===== verilog/lsi_pkg.sv
// types shared by the link status indicator
package lsi_pkg;
    typedef enum logic [1:0] {
        LSI_OFF    = 2'h0,
        LSI_GREEN  = 2'h1,
        LSI_ORANGE = 2'h2,
        LSI_RED    = 2'h3
    } lsi_color_t;
    typedef enum logic [1:0] {
        LSI_AUTOMATIC_MODE = 2'h0,
        LSI_MANUAL_MODE    = 2'h1,
        LSI_ADJUST_MODE    = 2'h2
    } lsi_mode_t;
endpackage

// ===== test/lsi_led_model.sv
// indicator side model: counts transitions of the summary lamp
`timescale 1ns/1ns

module lsi_led_model (
    // clock and reset
    input  wire logic  clk_i,
    input  wire logic  rst_b_i,
    // driven indicator
    input  wire logic  status_lamp_i,
    // observation
    output int unsigned lamp_edges_o
);
    logic lamp_ff;

    // a steady lamp gives no edges, a flashing one gives many
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lamp_ff      <= 1'b0;
            lamp_edges_o <= 0;
        end else begin
            lamp_ff <= status_lamp_i;
            if (lamp_ff !== status_lamp_i) begin
                lamp_edges_o <= lamp_edges_o + 1;
            end
        end
    end
endmodule // lsi_led_model

// ===== test/testbench.sv
// self-checking bench for the link status indicator
`timescale 1ns/1ns
`include "lsi_cfg.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end

module testbench;
    logic clk_i = 1'b0, rst_b_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata_o, rd;
    logic pready_o, pslverr_o, er, status_lamp_o, switching_output_one_o, tx_active_o;
    logic ol = 1'b0, oa = 1'b0, cl = 1'b0, ca = 1'b0, rc = 1'b0, rb = 1'b0, ls = 1'b0;
    logic ll = 1'b0, en = 1'b1;
    logic [3:0] strb = 4'hF;
    logic [3:0] lvl = 4'h0;
    logic [7:0] tmp = 8'h00, level_bar_o;
    logic [1:0] md = 2'h0, optical_link_led, err, cbl, con, tled;
    int unsigned lamp_edges;
    int miscompares = 0, n_tests = 0, cyc = 0;

    always #25 clk_i = ~clk_i;

    lsi_top #(.FLASH_HALF_CYC(4)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(strb),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .optical_link_up_i(ol), .optical_activity_i(oa), .cable_link_up_i(cl),
        .cable_activity_i(ca), .remote_cable_missing_i(rc), .remote_bar_empty_i(rb),
        .rx_level_i(lvl), .temp_excess_degc_i(tmp), .laser_prefailure_warning_i(ls),
        .link_loss_counter_trigger_i(ll), .optical_link_led_o(optical_link_led),
        .link_error_led_o(err), .cable_link_led_o(cbl),
        .connector_link_activity_led_o(con), .level_bar_o(level_bar_o),
        .temperature_warning_led_o(tled), .status_lamp_o(status_lamp_o),
        .switching_output_one_o(switching_output_one_o), .tx_active_o(tx_active_o));

    lsi_led_model leds (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .status_lamp_i(status_lamp_o), .lamp_edges_o(lamp_edges));

    task finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // apb master: no wait count is assumed, the timeout ends a stuck access
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        begin
            @(posedge clk_i);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_i);
            penable <= 1'b1;
            do @(posedge clk_i); while (pready_o !== 1'b1);
            rd = prdata_o;
            er = pslverr_o;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task drive(input logic a, b, c, d, e, f, input logic [3:0] l, input logic [7:0] t,
               input logic g, h);
        @(posedge clk_i);
        ol <= a;
        oa <= b;
        cl <= c;
        ca <= d;
        rc <= e;
        rb <= f;
        lvl <= l;
        tmp <= t;
        ls <= g;
        ll <= h;
        check;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // expected indicator states from the current stimulus and control settings
    task check;
        int unsigned e0;
        logic [3:0] lv;
        logic red, mm, warn, on;
        begin
            repeat (3) @(posedge clk_i);
            #1;
            lv = (lvl > 4'h8) ? 4'h8 : lvl;
            red = lv <= `LSI_RED_TOP;
            mm = !red && lv <= `LSI_ORANGE_TOP;
            warn = mm || tmp != 8'h00 || ls || ll;
            on = cl && en && !red;
            `CHK(level_bar_o, 8'((16'h0001 << lv) - 16'h0001))
            `CHK(switching_output_one_o, red || mm)
            `CHK(tx_active_o, en && ol && !red && !(mm && md != 2'h0))
            `CHK(optical_link_led, (!ol || red) ? lsi_pkg::LSI_OFF : oa ? lsi_pkg::LSI_ORANGE : lsi_pkg::LSI_GREEN)
            `CHK(err, (!cl || red) ? lsi_pkg::LSI_RED : (rc || rb) ? lsi_pkg::LSI_ORANGE : lsi_pkg::LSI_OFF)
            `CHK(cbl, !cl ? lsi_pkg::LSI_OFF : ca ? lsi_pkg::LSI_ORANGE : lsi_pkg::LSI_GREEN)
            `CHK(con, cbl)
            `CHK(tled, tmp == 8'h00 ? lsi_pkg::LSI_OFF : tmp <= `LSI_TEMP_WARN_DEGC ? lsi_pkg::LSI_ORANGE : lsi_pkg::LSI_RED)
            e0 = lamp_edges;
            repeat (12) @(posedge clk_i);
            #1;
            `CHK(lamp_edges != e0, on && warn)
            if (!(on && warn)) `CHK(status_lamp_o, on)
        end
    endtask

    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            finish_test;
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        `CHK({pready_o, tx_active_o, switching_output_one_o, level_bar_o}, 11'h000)
        rst_b_i <= 1'b1;
        apb(1'b0, `LSI_ADDR_CTRL, 32'h0);
        `CHK({er, rd}, {1'b0, `LSI_CTRL_RESET})
        apb(1'b0, 12'h008, 32'h0);
        `CHK({er, rd}, {1'b1, 32'h00000000})
        apb(1'b1, `LSI_ADDR_STAT, 32'hFFFFFFFF);
        `CHK(er, 1'b1)
        apb(1'b1, `LSI_ADDR_CTRL, 32'hFFFFFFFF);
        // only byte lane 1 enabled: enable and mode bits must survive
        strb <= 4'h2;
        apb(1'b1, `LSI_ADDR_CTRL, 32'h00000000);
        strb <= 4'hF;
        apb(1'b0, `LSI_ADDR_CTRL, 32'h0);
        `CHK(rd, 32'h00000007)
        // every mode against every level, including one above the top
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            apb(1'b1, `LSI_ADDR_CTRL, {29'h0, md, 1'b1});
            for (int l = 0; l < 10; l++) begin
                drive(1, 0, 1, 0, 0, 0, 4'(l), 8'h00, 0, 0);
            end
        end
        drive(1, 1, 1, 1, 0, 0, 4'h8, 8'h00, 0, 0);
        drive(1, 0, 0, 0, 0, 0, 4'h8, 8'h00, 0, 0);
        drive(1, 0, 1, 0, 1, 0, 4'h8, 8'h00, 0, 0);
        drive(1, 0, 1, 0, 0, 1, 4'h7, 8'h00, 0, 0);
        drive(0, 1, 1, 0, 0, 0, 4'h8, 8'h05, 0, 0);
        drive(1, 0, 1, 0, 0, 0, 4'h8, 8'h06, 0, 0);
        drive(1, 0, 1, 0, 0, 0, 4'h8, 8'h00, 1, 0);
        drive(1, 0, 1, 0, 0, 0, 4'h6, 8'h00, 0, 1);
        apb(1'b0, `LSI_ADDR_STAT, 32'h0);
        `CHK({rd[16], rd[7:0]}, {1'b1, 8'h3F})
        en = 1'b0;
        md = 2'h0;
        apb(1'b1, `LSI_ADDR_CTRL, 32'h00000000);
        check;
        finish_test;
    end
endmodule // testbench
